/* src/fso_fan_out.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Clock config top bit picks PWM source
// - Seven-bit prescale divides chosen source clock
// - PWM period is 256 prescaled ticks
// - Clock config matters only in PWM
// - Duty is value over 256, FFh full
// - DC mode uses bits 7-2, 64 steps
// - Mode config bit 6 selects PWM/DC
// - Mode config bits 5-4 pick control mode
// - Low nibble is temperature or speed tolerance
// - Target is temperature or eight-bit speed
// - Cold: lower drive down to stop value
// - Thermal start jumps from zero to start-up
// - Stop time sets stop-to-zero delay
// - Stepped mode caps drive at maximum
// - Stepped mode moves by step register
module fso_fan_out #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned STEP_CYCLES = fso_pkg::STEP_INTERVAL_CYCLES,
  parameter int unsigned STOP_PWM_CYCLES = fso_pkg::STOP_UNIT_PWM_CYCLES,
  parameter int unsigned STOP_DC_CYCLES = fso_pkg::STOP_UNIT_DC_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Monitor inputs
  input wire logic [6:0] cur_temp,
  input wire logic [7:0] fan_tach_b,
  // Fan drive outputs
  output logic fan_drive_b_pwm,
  output logic [5:0] fan_drive_b_dc,
  output logic fan_drive_b_is_dc,
  output logic [7:0] fan_drive_a_max,
  output logic [7:0] fan_drive_a_step
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [fso_pkg::NUM_REGS*8-1:0] regs; // Register file
    logic [7:0] drive; // Live drive value
    fso_pkg::fso_auto_e phase; // Automatic sequencing phase
    logic [27:0] acc; // Source clock phase accumulator
    logic [6:0] pre; // Prescale counter
    logic [7:0] pwm_cnt; // Position in PWM period
    logic pwm_out; // Registered PWM pin
    logic [5:0] dc_out; // Registered DC level
    logic [31:0] step_tmr; // Step interval timer
    logic [31:0] unit_tmr; // Stop time unit timer
    logic [7:0] units; // Elapsed stop time units
    logic aw_got; // Write address held
    logic [9:0] aw_idx; // Held write index
    logic w_got; // Write data held
    logic [7:0] w_byte; // Held write low byte
    logic w_lane0; // Low byte lane enabled
    logic bvalid; // Write response pending
    logic [1:0] bresp; // Write response code
    logic rvalid; // Read data pending
    logic [31:0] rdata; // Read data
    logic [1:0] rresp; // Read response code
  } fso_state_s;

  fso_state_s st_reg; // Registered state
  fso_state_s st_next; // Next state

  // Register fields, decoded from the file
  logic [7:0] clk_cfg; // Source select and prescale
  logic [7:0] out_val; // Software output value
  logic [7:0] mode_cfg; // Output type, mode, tolerance
  logic [7:0] target; // Target temperature or speed
  logic [7:0] stop_val; // Lowest running drive
  logic [7:0] startup; // Thermal start-up drive
  logic [7:0] stop_time; // Units from stop value to zero
  logic [7:0] b_max; // Stepped mode ceiling
  logic [7:0] b_step; // Stepped mode increment

  assign clk_cfg = st_reg.regs[7:0];
  assign out_val = st_reg.regs[15:8];
  assign mode_cfg = st_reg.regs[23:16];
  assign target = st_reg.regs[31:24];
  assign stop_val = st_reg.regs[39:32];
  assign startup = st_reg.regs[47:40];
  assign stop_time = st_reg.regs[55:48];
  assign b_max = st_reg.regs[79:72];
  assign b_step = st_reg.regs[87:80];

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Unmapped index answers zero data and a slave error
  function automatic logic [32:0] read_word(input logic [9:0] idx,
                                            input fso_state_s s);
    logic [32:0] res;
    res = {1'b1, 32'h0000_0000};
    if (idx >= fso_pkg::IDX_CLK_CFG && idx <= fso_pkg::IDX_B_STEP) begin
      res = {1'b0, 24'h00_0000, s.regs[8*(idx - fso_pkg::IDX_CLK_CFG) +: 8]};
    end else if (idx == fso_pkg::IDX_DRIVE_STAT) begin
      res = {1'b0, 24'h00_0000, s.drive};
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] mode;
    logic dc_mode;
    logic [8:0] tol;
    logic [8:0] hi_lim;
    logic [8:0] lo_lim;
    logic [8:0] meas;
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [7:0] stepv;
    logic [7:0] cap;
    logic [7:0] div;
    logic [28:0] acc_sum;
    logic src_tick;
    logic step_tick;
    logic [32:0] rd;
    logic aw_hs;
    logic w_hs;
    mode = mode_cfg[fso_pkg::MODE_HI:fso_pkg::MODE_LO];
    dc_mode = mode_cfg[fso_pkg::OUT_DC_BIT];
    tol = {5'b0_0000, mode_cfg[fso_pkg::TOL_HI:0]};
    meas = 9'h000;
    sum9 = 9'h000;
    dif9 = 9'h000;
    stepv = 8'h01;
    cap = 8'hff;
    rd = 33'h0_0000_0000;
    st_next = st_reg;

    // ---- Write channel: address and data taken in either order ----
    aw_hs = s_axi_awvalid && !st_reg.aw_got && !st_reg.bvalid;
    w_hs = s_axi_wvalid && !st_reg.w_got && !st_reg.bvalid;
    if (aw_hs) begin
      st_next.aw_got = 1'b1;
      st_next.aw_idx = s_axi_awaddr[11:2];
    end
    if (w_hs) begin
      st_next.w_got = 1'b1;
      st_next.w_byte = s_axi_wdata[7:0];
      st_next.w_lane0 = s_axi_wstrb[0];
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Commit once both halves are held
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = fso_pkg::RESP_SLVERR;
      if (st_reg.aw_idx >= fso_pkg::IDX_CLK_CFG && st_reg.aw_idx <= fso_pkg::IDX_B_STEP) begin
        st_next.bresp = fso_pkg::RESP_OKAY;
        if (st_reg.w_lane0) begin
          st_next.regs[8*(st_reg.aw_idx - fso_pkg::IDX_CLK_CFG) +: 8] = st_reg.w_byte;
        end
      end else if (st_reg.aw_idx == fso_pkg::IDX_DRIVE_STAT) begin
        // Status is read-only; write ignored but accepted
        st_next.bresp = fso_pkg::RESP_OKAY;
      end
    end

    // ---- Read channel: one cycle from address to data ----
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      rd = read_word(s_axi_araddr[11:2], st_reg);
      st_next.rvalid = 1'b1;
      st_next.rdata = rd[31:0];
      st_next.rresp = rd[32] ? fso_pkg::RESP_SLVERR : fso_pkg::RESP_OKAY;
    end

    // ---- PWM timebase ----
    // fast or slow source from phase accumulator
    acc_sum = {1'b0, st_reg.acc} +
      {1'b0, (clk_cfg[fso_pkg::CLK_SRC_BIT] ? fso_pkg::ACC_SLOW : fso_pkg::ACC_FAST)};
    src_tick = acc_sum >= {1'b0, fso_pkg::ACC_MOD};
    st_next.acc = src_tick ? 28'(acc_sum - {1'b0, fso_pkg::ACC_MOD}) : acc_sum[27:0];
    // prescale divider; a zero code acts as one
    div = (clk_cfg[6:0] == 7'h00) ? 8'h01 : {1'b0, clk_cfg[6:0]};
    if (src_tick) begin
      if ({1'b0, st_reg.pre} + 8'h01 >= div) begin
        st_next.pre = 7'h00;
        st_next.pwm_cnt = st_reg.pwm_cnt + 8'h01;
      end else begin
        st_next.pre = st_reg.pre + 7'h01;
      end
    end

    // ---- Pin drive ----
    // timebase ignored in DC mode
    if (dc_mode) begin
      st_next.pwm_out = 1'b0;
      st_next.dc_out = st_reg.drive[7:2];
    end else begin
      // high for value/256, FFh held high
      st_next.pwm_out = (st_reg.drive == 8'hff) || (st_reg.pwm_cnt < st_reg.drive);
      st_next.dc_out = 6'h00;
    end

    // ---- Step interval ----
    // one adjustment per interval
    step_tick = st_reg.step_tmr >= STEP_CYCLES - 1;
    st_next.step_tmr = step_tick ? 32'h0000_0000 : st_reg.step_tmr + 32'h0000_0001;

    // ---- Automatic control ----
    // target width depends on mode
    if (mode == fso_pkg::MODE_SPEED) begin
      meas = {1'b0, fan_tach_b};
      hi_lim = {1'b0, target} + tol;
      lo_lim = ({1'b0, target} > tol) ? {1'b0, target} - tol : 9'h000;
    end else begin
      meas = {2'b00, cur_temp};
      hi_lim = {2'b00, target[6:0]} + tol;
      lo_lim = ({2'b00, target[6:0]} > tol) ? {2'b00, target[6:0]} - tol : 9'h000;
    end
    if (mode == fso_pkg::MODE_STEPPED) begin
      stepv = b_step;
      cap = b_max;
    end

    case (mode)
      fso_pkg::MODE_MANUAL: begin
        st_next.drive = out_val;
        st_next.phase = fso_pkg::FSO_RUN;
      end
      fso_pkg::MODE_SPEED: begin
        st_next.phase = fso_pkg::FSO_RUN;
        if (step_tick && meas < lo_lim && st_reg.drive != 8'hff) begin
          st_next.drive = st_reg.drive + 8'h01;
        end else if (step_tick && meas > hi_lim && st_reg.drive != 8'h00) begin
          st_next.drive = st_reg.drive - 8'h01;
        end
      end
      fso_pkg::MODE_THERMAL, fso_pkg::MODE_STEPPED: begin
        if (step_tick && meas > hi_lim) begin
          st_next.phase = fso_pkg::FSO_RUN;
          if (st_reg.drive == 8'h00) begin
            // kick from zero to start-up value in thermal mode, to stop value in stepped mode
            st_next.drive = (mode == fso_pkg::MODE_THERMAL) ? startup : stop_val;
          end else begin
            sum9 = {1'b0, st_reg.drive} + {1'b0, stepv};
            st_next.drive = (sum9 > {1'b0, cap}) ? cap : sum9[7:0];
          end
        end else if (step_tick && meas < lo_lim && st_reg.phase == fso_pkg::FSO_RUN) begin
          // lower toward stop value, never past it
          if (st_reg.drive > stop_val) begin
            dif9 = {1'b0, st_reg.drive} - {1'b0, stepv};
            st_next.drive = (dif9[8] || dif9[7:0] < stop_val) ? stop_val : dif9[7:0];
          end else begin
            st_next.drive = stop_val;
            st_next.phase = fso_pkg::FSO_HOLD;
          end
        end
      end
      default: begin
        st_next.phase = fso_pkg::FSO_RUN;
      end
    endcase

    // stop time from stop value to zero
    if (st_next.phase == fso_pkg::FSO_HOLD && st_reg.phase == fso_pkg::FSO_HOLD) begin
      if (st_reg.unit_tmr >= (dc_mode ? STOP_DC_CYCLES : STOP_PWM_CYCLES) - 1) begin
        st_next.unit_tmr = 32'h0000_0000;
        st_next.units = st_reg.units + 8'h01;
      end else begin
        st_next.unit_tmr = st_reg.unit_tmr + 32'h0000_0001;
      end
      if (st_reg.units >= stop_time) begin
        st_next.drive = 8'h00;
        st_next.phase = fso_pkg::FSO_OFF;
      end
    end else begin
      // Timer restarts whenever hold is entered anew
      st_next.unit_tmr = 32'h0000_0000;
      st_next.units = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.regs <= fso_pkg::REG_RESET;
      st_reg.drive <= 8'hff;
      st_reg.phase <= fso_pkg::FSO_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ready terms are combinational; all data comes from flops
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign fan_drive_b_pwm = st_reg.pwm_out;
  assign fan_drive_b_dc = st_reg.dc_out;
  assign fan_drive_b_is_dc = mode_cfg[fso_pkg::OUT_DC_BIT];
  assign fan_drive_a_max = st_reg.regs[63:56];
  assign fan_drive_a_step = st_reg.regs[71:64];

endmodule // fso_fan_out

/* src/fso_pkg.sv */
package fso_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000; // System clock rate
  localparam int unsigned SRC_FAST_HZ = 24_000_000; // Fast PWM source
  localparam int unsigned SRC_SLOW_HZ = 180_000; // Slow PWM source
  localparam int unsigned STOP_UNIT_PWM_MS = 100; // Stop time unit, PWM
  localparam int unsigned STOP_UNIT_DC_MS = 400; // Stop time unit, DC
  localparam int unsigned STEP_INTERVAL_MS = 100; // Auto step interval
  localparam int unsigned STOP_UNIT_PWM_CYCLES =
    32'(64'(STOP_UNIT_PWM_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam int unsigned STOP_UNIT_DC_CYCLES =
    32'(64'(STOP_UNIT_DC_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam int unsigned STEP_INTERVAL_CYCLES =
    32'(64'(STEP_INTERVAL_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam logic [27:0] ACC_MOD = 28'(CLK_HZ); // Phase accumulator wrap
  localparam logic [27:0] ACC_FAST = 28'(SRC_FAST_HZ);
  localparam logic [27:0] ACC_SLOW = 28'(SRC_SLOW_HZ);

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CLK_CFG = 10'h060;
  localparam logic [9:0] IDX_OUT_VAL = 10'h061;
  localparam logic [9:0] IDX_MODE_CFG = 10'h062;
  localparam logic [9:0] IDX_TARGET = 10'h063;
  localparam logic [9:0] IDX_STOP_VAL = 10'h064;
  localparam logic [9:0] IDX_STARTUP = 10'h065;
  localparam logic [9:0] IDX_STOP_TIME = 10'h066;
  localparam logic [9:0] IDX_A_MAX = 10'h067;
  localparam logic [9:0] IDX_A_STEP = 10'h068;
  localparam logic [9:0] IDX_B_MAX = 10'h069;
  localparam logic [9:0] IDX_B_STEP = 10'h06a;
  localparam logic [9:0] IDX_DRIVE_STAT = 10'h06b; // Live drive value
  localparam int unsigned NUM_REGS = 11;

  // ----------------------------------------------------------------
  // Reset values, from the last index down to the clock config
  // ----------------------------------------------------------------
  localparam logic [NUM_REGS*8-1:0] REG_RESET = {
    8'h01, 8'hff, 8'h01, 8'hff, 8'h3c, 8'h00,
    8'h01, 8'h00, 8'h40, 8'hff, 8'h04};

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int unsigned CLK_SRC_BIT = 7;
  localparam int unsigned OUT_DC_BIT = 6;
  localparam int unsigned MODE_HI = 5;
  localparam int unsigned MODE_LO = 4;
  localparam int unsigned TOL_HI = 3;
  localparam logic [1:0] MODE_MANUAL = 2'b00;
  localparam logic [1:0] MODE_THERMAL = 2'b01;
  localparam logic [1:0] MODE_SPEED = 2'b10;
  localparam logic [1:0] MODE_STEPPED = 2'b11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Automatic drive sequencing
  typedef enum logic [2:0] {
    FSO_RUN = 3'b001,
    FSO_HOLD = 3'b010,
    FSO_OFF = 3'b100
  } fso_auto_e;
endpackage

/* verif/fso_fan_model.sv */
`timescale 1ns/1ps
// ------------------------------------------
// Fan with tachometer, speed lags the drive
// ------------------------------------------
module fso_fan_model #(
  parameter int unsigned LAG = 4 // Cycles per tach unit; 1 is prompt
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Drive from the block
  input wire logic pwm_in,
  input wire logic [5:0] dc_in,
  input wire logic is_dc,
  // Measured speed, larger is faster
  output logic [7:0] tach
);
  logic [7:0] goal; // Speed the rotor heads for
  int unsigned cnt; // Inertia counter
  // Rotor inertia, one tach unit per LAG cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tach <= 8'h00;
      cnt <= 0;
    end else if (cnt + 1 >= LAG) begin
      cnt <= 0;
      if (tach < goal) tach <= tach + 8'h01;
      else if (tach > goal) tach <= tach - 8'h01;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // PWM is full or nothing, so the rotor averages the duty
  assign goal = is_dc ? {dc_in, 2'b00} : {8{pwm_in}};
endmodule // fso_fan_model

/* verif/fso_fan_out_asserts.sv */
`timescale 1ns/1ps
// ------------------------------------------
// Port checks for the fan output block
// ------------------------------------------
module fso_fan_out_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Fan drive
  input wire logic fan_drive_b_pwm,
  input wire logic [5:0] fan_drive_b_dc,
  input wire logic fan_drive_b_is_dc
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("write answered twice");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read answered twice");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken under response");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken under response");
  // Unused upper data and empty error data
  property p_rd_data;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (s_axi_rresp == 2'b00 || s_axi_rdata == 0);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not clean");
  property p_dc_quiet;
    fan_drive_b_is_dc ##1 fan_drive_b_is_dc |-> !fan_drive_b_pwm;
  endproperty
  a_dc_quiet: assert property (p_dc_quiet) else $error("pulse in voltage form");
  property p_pwm_quiet;
    !fan_drive_b_is_dc ##1 !fan_drive_b_is_dc |-> fan_drive_b_dc == 6'h00;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("level in pulse form");
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_rise: cover property ($rose(fan_drive_b_pwm));
  c_dc: cover property (fan_drive_b_is_dc && fan_drive_b_dc == 6'h1c);
endmodule // fso_fan_out_asserts

bind fso_fan_out fso_fan_out_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .fan_drive_b_pwm(fan_drive_b_pwm), .fan_drive_b_dc(fan_drive_b_dc),
  .fan_drive_b_is_dc(fan_drive_b_is_dc));

/* verif/fso_fan_out_tb.sv */
`timescale 1ns/1ps
module fso_fan_out_tb;
  // ------------------------------------------
  // Signals and design
  // ------------------------------------------
  typedef struct {logic [7:0] cfg; logic [7:0] duty; int per; int hi;} fso_row_s;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pwm, is_dc;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [6:0] cur_temp;
  logic [7:0] tach, a_max, a_step, v, p;
  logic [5:0] dc;
  int fail_count, total_checks, h, e, c, k;
  // Clock periods per row assume a 100 MHz clock on a 24 MHz source
  fso_row_s rows [3] = '{'{8'h01, 8'h80, 1067, 533}, '{8'h02, 8'h40, 2133, 533},
    '{8'h03, 8'hc0, 3200, 2400}};
  logic [7:0] rst_tab [11] = '{8'h04, 8'hff, 8'h40, 8'h00, 8'h01, 8'h00, 8'h3c, 8'hff,
    8'h01, 8'hff, 8'h01};
  // Short timers keep the automatic modes quick
  fso_fan_out #(.STEP_CYCLES(8), .STOP_PWM_CYCLES(4), .STOP_DC_CYCLES(12)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cur_temp(cur_temp), .fan_tach_b(tach), .fan_drive_b_pwm(pwm), .fan_drive_b_dc(dc),
    .fan_drive_b_is_dc(is_dc), .fan_drive_a_max(a_max), .fan_drive_a_step(a_step));
  fso_fan_model #(.LAG(4)) u_fan (.clk(aclk), .rst_n(aresetn), .pwm_in(pwm), .dc_in(dc),
    .is_dc(is_dc), .tach(tach));
  // ------------------------------------------
  // Compare and report
  // ------------------------------------------
  task automatic err(input string m);
    fail_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_val(input logic [7:0] g, input logic [7:0] x);
    total_checks++;
    if (g !== x) err($sformatf("value %h, wanted %h", g, x));
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] x);
    total_checks++;
    if (g !== x) err($sformatf("response %b, wanted %b", g, x));
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    total_checks++;
    if (g < lo || g > hi) err($sformatf("count %0d outside %0d..%0d", g, lo, hi));
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------------------
  // Bus master, one transfer at a time
  // ------------------------------------------
  // Ready is judged at the falling edge, so it is the value the next edge sees
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic [1:0] rs);
    logic ta, tw, done;
    int n;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
    end
    done = 1'b0;
    n = 0;
    while (!done && n < 200) begin
      @(negedge aclk);
      ta = w ? awvalid && awready : arvalid && arready;
      tw = wvalid && wready;
      done = w ? bvalid : rvalid;
      q = rdata[7:0];
      rs = w ? bresp : rresp;
      @(posedge aclk);
      if (ta && w) awvalid <= 1'b0;
      if (ta && !w) arvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    if (!done) err("bus hang");
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    bus(1'b1, {i, 2'b00}, d, v, r);
    chk_resp(r, fso_pkg::RESP_OKAY);
  endtask
  task automatic rdc(input logic [9:0] i, input logic [7:0] x);
    bus(1'b0, {i, 2'b00}, 8'h00, v, r);
    chk_resp(r, fso_pkg::RESP_OKAY);
    chk_val(v, x);
  endtask
  // Read the live drive until it moves off old; cycles taken in t
  task automatic poll(input logic [7:0] old, output logic [7:0] nv, output int t);
    time t0;
    int n;
    t0 = $time;
    n = 0;
    do begin
      bus(1'b0, {fso_pkg::IDX_DRIVE_STAT, 2'b00}, 8'h00, nv, r);
      n++;
    end while (nv === old && n < 300);
    t = int'(($time - t0) / 10);
  endtask
  // High cycles and rising edges of the pulse pin over n cycles
  task automatic scan(input int n, output int hs, output int es);
    logic q;
    hs = 0;
    es = 0;
    // New drive needs two edges to reach the pin
    repeat (2) @(posedge aclk);
    q = pwm;
    repeat (n) begin
      @(negedge aclk);
      hs += int'(pwm === 1'b1);
      es += int'(pwm === 1'b1 && q === 1'b0);
      q = pwm;
    end
    @(posedge aclk);
  endtask
  // Length of high phase and whole period from one rising edge
  task automatic meas(output int hs, output int per);
    int n;
    n = 0;
    do @(negedge aclk); while (pwm !== 1'b0 && ++n < 9000);
    do @(negedge aclk); while (pwm !== 1'b1 && ++n < 9000);
    hs = 0;
    while (pwm === 1'b1 && hs < 9000) begin
      @(negedge aclk);
      hs++;
    end
    per = hs;
    while (pwm === 1'b0 && per < 9000) begin
      @(negedge aclk);
      per++;
    end
    @(posedge aclk);
  endtask
  // ------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Whole run is near 25k cycles; give it 100k
  initial begin
    #1_000_000;
    err("watchdog");
    conclude();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb, cur_temp} = {2'b11, 4'hf, 7'h00};
    repeat (12) @(posedge aclk);
    chk_val({7'h0, pwm}, 8'h00);
    aresetn <= 1'b1;
    for (k = 0; k < 11; k++) rdc(fso_pkg::IDX_CLK_CFG + 10'(k), rst_tab[k]);
    chk_val({2'b0, dc}, 8'h3f);
    chk_val({7'h0, is_dc}, 8'h01);
    bus(1'b0, 12'h1b0, 8'h00, v, r);
    chk_resp(r, fso_pkg::RESP_SLVERR);
    bus(1'b1, 12'h000, 8'h5a, v, r);
    chk_resp(r, fso_pkg::RESP_SLVERR);
    wr(fso_pkg::IDX_DRIVE_STAT, 8'h12);
    rdc(fso_pkg::IDX_DRIVE_STAT, 8'hff);
    wr(fso_pkg::IDX_CLK_CFG, 8'h01);
    wr(fso_pkg::IDX_OUT_VAL, 8'hb7);
    scan(1200, h, e);
    chk_rng(h, 0, 0);
    chk_val({2'b0, dc}, 8'h2d);
    wr(fso_pkg::IDX_MODE_CFG, 8'h00);
    foreach (rows[i]) begin
      wr(fso_pkg::IDX_CLK_CFG, rows[i].cfg);
      wr(fso_pkg::IDX_OUT_VAL, rows[i].duty);
      meas(h, c);
      chk_rng(c, rows[i].per - 8, rows[i].per + 8);
      chk_rng(h, rows[i].hi - 8, rows[i].hi + 8);
    end
    for (k = 0; k < 2; k++) begin
      wr(fso_pkg::IDX_OUT_VAL, {8{k[0]}});
      scan(1200, h, e);
      chk_rng(h, k * 1200, k * 1200);
    end
    wr(fso_pkg::IDX_OUT_VAL, 8'h80);
    wr(fso_pkg::IDX_CLK_CFG, 8'h81);
    scan(3000, h, e);
    chk_rng(e, 0, 1);
    wr(fso_pkg::IDX_A_MAX, 8'h55);
    wr(fso_pkg::IDX_A_STEP, 8'h07);
    chk_val(a_max, 8'h55);
    chk_val(a_step, 8'h07);
    wr(fso_pkg::IDX_CLK_CFG, 8'h01);
    wr(fso_pkg::IDX_OUT_VAL, 8'h00);
    wr(fso_pkg::IDX_STOP_VAL, 8'h10);
    wr(fso_pkg::IDX_STARTUP, 8'h30);
    wr(fso_pkg::IDX_STOP_TIME, 8'h0a);
    wr(fso_pkg::IDX_TARGET, 8'h28);
    cur_temp <= 7'd60;
    wr(fso_pkg::IDX_MODE_CFG, 8'h10);
    poll(8'h00, v, c);
    chk_val(v, 8'h30);
    cur_temp <= 7'd10;
    for (k = 0; k < 40 && v !== 8'h10; k++) begin
      p = v;
      poll(p, v, c);
      chk_val(v, p - 8'h01);
    end
    poll(8'h10, v, c);
    chk_val(v, 8'h00);
    chk_rng(c, 40, 70);
    wr(fso_pkg::IDX_B_STEP, 8'h20);
    wr(fso_pkg::IDX_B_MAX, 8'h70);
    wr(fso_pkg::IDX_MODE_CFG, 8'h70);
    cur_temp <= 7'd60;
    v = 8'h00;
    for (k = 0; k < 4; k++) begin
      p = v;
      poll(p, v, c);
      chk_val(v, 8'h10 + 8'(k * 32));
    end
    repeat (60) @(posedge aclk);
    rdc(fso_pkg::IDX_DRIVE_STAT, 8'h70);
    chk_val({2'b0, dc}, 8'h1c);
    cur_temp <= 7'd10;
    for (k = 0; k < 3; k++) poll(v, v, c);
    chk_val(v, 8'h10);
    poll(8'h10, v, c);
    chk_rng(c, 120, 150);
    wr(fso_pkg::IDX_TARGET, 8'h80);
    wr(fso_pkg::IDX_MODE_CFG, 8'h62);
    repeat (4000) @(posedge aclk);
    chk_rng(int'(tach), 8'h80 - 12, 8'h80 + 12);
    wr(fso_pkg::IDX_MODE_CFG, 8'h40);
    wr(fso_pkg::IDX_OUT_VAL, 8'h9c);
    repeat (3) @(posedge aclk);
    chk_val({2'b0, dc}, 8'h27);
    conclude();
  end
endmodule // fso_fan_out_tb
